// ===== tss_regs_top.sv
// serial command port, register use, output switch routing and pulse level select
//
// Behaviour
// R1: route gate pin high applies route select
// R2: gate low opens switch, except digital mode
// R3: digital mode routes from register, ignores gate
// R4: codes 000 open, 001 straight, 010 cross, 011 positive
// R5: codes 100 negative, 101/110 single, 111 short
// R6: top route register bit picks tone band
// R7: low route nibble is tone multiplier
// R8: separate divisor byte also sets tone
// R9: three bytes form 24-bit steady gain
// R10: host writes zero to reserved level bits
// R11: pulse mode: select pin picks level a/b
// R12: pulse level from own code, range-independent
// R13: route at 02h, levels at 07h, 08h
// R14: two-bit mode; mode change restarts generator
// R15: opcode, count minus one, data msb first
// R16: register pointer advances and never wraps
// R17: tone fields feed frequency synthesis
// R18: steady gain feeds level mapping
`timescale 1ns/1ns
module tss_regs_top (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic chip_sel_low,
  input wire logic sclk,
  input wire logic sdin,
  output logic sdout,
  output logic sdout_oe_low,
  input wire logic route_gate_pin,
  input wire logic level_sel_pin,
  output logic [4:0] switch_close,
  output logic [1:0] op_mode,
  output logic [2:0] range_sel,
  output tss_pkg::tss_byte_t sine_gain,
  output logic tone_band_bit,
  output logic [3:0] tone_mult,
  output tss_pkg::tss_byte_t tone_divisor,
  output logic [23:0] steady_level_gain,
  output logic [4:0] level_out,
  output logic gen_restart
);
  import tss_pkg::*;

  tss_reg_if rb ();

  tss_reg_bank #(
    .NUM_REGS(REG_CNT),
    .ID_VALUE(3'h5)
  ) u_bank (
    .core_clk(core_clk),
    .rst(rst),
    .rb(rb)
  );

  // pin synchronisers: [0] chip select [1] sclk [2] data in [3] route gate [4] level select
  logic [4:0] meta_r;
  logic [4:0] sync_r;
  logic sclk_prev_r;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      meta_r <= 5'h01;
      sync_r <= 5'h01;
    end else begin
      meta_r <= {level_sel_pin, route_gate_pin, sdin, sclk, chip_sel_low};
      sync_r <= meta_r;
    end
  end

  // edge finder looks only at the second stage
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sclk_prev_r <= 1'b0;
    end else begin
      sclk_prev_r <= sync_r[1];
    end
  end

  logic cs_act;
  logic sclk_rise;
  logic sclk_fall;
  logic gate_s;
  logic lvl_sel_s;
  assign cs_act = ~sync_r[0];
  assign sclk_rise = sync_r[1] & ~sclk_prev_r;
  assign sclk_fall = ~sync_r[1] & sclk_prev_r;
  assign gate_s = sync_r[3];
  assign lvl_sel_s = sync_r[4];

  // command engine state
  tss_state_t state_r;
  logic [2:0] bit_cnt_r;
  tss_byte_t sh_r;
  logic [3:0] opc_r;
  logic [4:0] ptr_r;
  logic [3:0] left_r;

  tss_byte_t rx_byte;
  logic byte_done;
  assign rx_byte = {sh_r[6:0], sync_r[2]};
  assign byte_done = cs_act && sclk_rise && (bit_cnt_r == 3'h7);

  // input bits are taken on sclk rising edges, msb first
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sh_r <= 8'h00;
      bit_cnt_r <= 3'h0;
    end else if (!cs_act) begin
      bit_cnt_r <= 3'h0; // chip select high drops a partial byte
    end else if (sclk_rise) begin
      sh_r <= rx_byte; // R15
      bit_cnt_r <= bit_cnt_r + 3'h1;
    end
  end

  // opcode, count, then data bytes; holding select low lets the next command follow
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_OP1;
      opc_r <= 4'h0;
      ptr_r <= 5'h00;
      left_r <= 4'h0;
    end else if (!cs_act) begin
      state_r <= ST_OP1;
    end else if (byte_done) begin
      case (state_r)
        ST_OP1: begin
          if (rx_byte[7:4] == OPC_WRITE || rx_byte[7:4] == OPC_READ) begin
            opc_r <= rx_byte[7:4]; // R15
            ptr_r <= {1'b0, rx_byte[3:0]};
            state_r <= ST_OP2;
          end
        end
        ST_OP2: begin
          left_r <= rx_byte[3:0]; // R15
          state_r <= ST_DATA;
        end
        ST_DATA: begin
          ptr_r <= ptr_r + 5'h01; // R16
          if (left_r == 4'h0) begin
            state_r <= ST_OP1;
          end else begin
            left_r <= left_r - 4'h1;
          end
        end
        default: state_r <= ST_OP1;
      endcase
    end
  end

  // bank access; the pointer starts at most at 15 and runs at most 16 bytes, so it cannot wrap
  assign rb.we = byte_done && state_r == ST_DATA && opc_r == OPC_WRITE; // R15
  assign rb.wdata = rx_byte;
  assign rb.addr = ptr_r; // R16
  assign rb.soft_clr = byte_done && state_r == ST_OP1 && rx_byte[7:1] == OPC_RESET;

  // read data leave on falling edges; the bank answers a cycle after the pointer moves,
  // well before the next falling edge at any legal sclk rate
  tss_byte_t tx_r;
  logic reading;
  assign reading = cs_act && state_r == ST_DATA && opc_r == OPC_READ;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_r <= 8'h00;
      sdout <= 1'b0;
      sdout_oe_low <= 1'b1;
    end else begin
      sdout_oe_low <= ~reading;
      if (reading && sclk_fall) begin
        if (bit_cnt_r == 3'h0) begin
          sdout <= rb.rdata[7]; // R15
          tx_r <= {rb.rdata[6:0], 1'b0};
        end else begin
          sdout <= tx_r[7];
          tx_r <= {tx_r[6:0], 1'b0};
        end
      end
    end
  end

  // register fields in use
  logic [1:0] mode;
  logic [2:0] path_select_bits;
  logic [4:0] level_a_code;
  logic [4:0] level_b_code;
  assign mode = rb.regs[ADR_MODE][MODE_LSB +: 2]; // R14
  assign path_select_bits = rb.regs[ADR_ROUTE][PATH_LSB +: 3];
  assign level_a_code = rb.regs[ADR_LVL_A][LVL_W-1:0];
  assign level_b_code = rb.regs[ADR_LVL_B][LVL_W-1:0];

  // switch routing; the gate pin is bypassed only in digital data mode
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      switch_close <= CLS_OPEN;
    end else if (mode == MODE_DIGITAL) begin
      switch_close <= route_decode(path_select_bits); // R3 R4 R5
    end else if (gate_s) begin
      switch_close <= route_decode(path_select_bits); // R1 R4 R5
    end else begin
      switch_close <= CLS_OPEN; // R2
    end
  end

  // tone and gain settings handed to the synthesis datapath
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      op_mode <= MODE_SINE;
      range_sel <= RST_MODE_REG[RANGE_LSB +: 3];
      sine_gain <= RST_OTHER;
      tone_band_bit <= 1'b0;
      tone_mult <= 4'h0;
      tone_divisor <= RST_DIVISOR;
      steady_level_gain <= 24'h000000;
    end else begin
      op_mode <= mode; // R14
      range_sel <= rb.regs[ADR_MODE][RANGE_LSB +: 3];
      sine_gain <= rb.regs[ADR_SINE_GAIN];
      tone_band_bit <= rb.regs[ADR_ROUTE][BAND_BIT]; // R6 R17
      tone_mult <= rb.regs[ADR_ROUTE][MULT_LSB +: 4]; // R7 R17
      tone_divisor <= rb.regs[ADR_DIVISOR]; // R8 R17
      steady_level_gain <= {rb.regs[ADR_GAIN2], rb.regs[ADR_GAIN1], rb.regs[ADR_GAIN0]}; // R9 R18
    end
  end

  // pulse level: the range field never enters this path
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      level_out <= 5'h00;
    end else if (mode != MODE_PULSE) begin
      level_out <= 5'h00;
    end else if (lvl_sel_s) begin
      level_out <= level_b_code; // R11 R12
    end else begin
      level_out <= level_a_code; // R11 R12
    end
  end

  // one-cycle restart of the generator whenever the mode field changes
  logic [1:0] mode_prev_r;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode_prev_r <= MODE_SINE;
      gen_restart <= 1'b0;
    end else begin
      mode_prev_r <= mode;
      gen_restart <= (mode != mode_prev_r); // R14
    end
  end

  a_switch_gated: assert property (@(posedge core_clk) disable iff (rst)
    (gate_s && mode != MODE_DIGITAL) |=> switch_close == route_decode($past(path_select_bits))) // R1
    else $error("switch does not follow route select while gated");

  a_switch_forced_open: assert property (@(posedge core_clk) disable iff (rst)
    (!gate_s && mode != MODE_DIGITAL) |=> switch_close == CLS_OPEN) // R2
    else $error("switch not open while gate low");

  a_switch_digital_mode: assert property (@(posedge core_clk) disable iff (rst)
    (mode == MODE_DIGITAL && !gate_s) |=> switch_close == route_decode($past(path_select_bits))) // R3
    else $error("digital mode switch depends on gate");

  a_route_cross: assert property (@(posedge core_clk) disable iff (rst)
    (gate_s && path_select_bits == 3'h2) |=> switch_close == (CLS_PN | CLS_NP)) // R4
    else $error("cross route wrong");

  a_route_short: assert property (@(posedge core_clk) disable iff (rst)
    (mode == MODE_DIGITAL && path_select_bits == 3'h7) |=> switch_close == CLS_SHORT) // R5
    else $error("short route wrong");

  a_tone_fields: assert property (@(posedge core_clk) disable iff (rst)
    $changed(rb.regs[ADR_ROUTE]) |=> tone_band_bit == $past(rb.regs[ADR_ROUTE][7])
      && tone_mult == $past(rb.regs[ADR_ROUTE][3:0])) // R6
    else $error("tone fields lag route register");

  a_gain_order: assert property (@(posedge core_clk) disable iff (rst)
    rb.we && rb.addr == ADR_GAIN2 |=> ##1 steady_level_gain[23:16] == $past(rb.wdata, 2)) // R9
    else $error("steady gain high byte misplaced");

  a_pulse_level_b: assert property (@(posedge core_clk) disable iff (rst)
    (mode == MODE_PULSE && lvl_sel_s) |=> level_out == $past(level_b_code)) // R11
    else $error("pulse level b not selected");

  a_mode_restart: assert property (@(posedge core_clk) disable iff (rst)
    $changed(mode) |=> gen_restart ##1 (gen_restart == ($past(mode) != $past(mode, 2)))) // R14
    else $error("mode change did not restart generator");

  a_ptr_forward: assert property (@(posedge core_clk) disable iff (rst)
    (state_r == ST_DATA && byte_done) |=> ptr_r == $past(ptr_r) + 5'h01) // R16
    else $error("register pointer did not advance");

  a_read_quiet: assert property (@(posedge core_clk) disable iff (rst)
    !cs_act |=> sdout_oe_low) // R15
    else $error("data out driven without chip select");
endmodule

// ===== tss_pkg.sv
// shared constants, types and decode for the test signal switch and pulse registers
package tss_pkg;

  // register map
  localparam int REG_CNT = 9;
  localparam logic [4:0] ADR_MODE = 5'h00;
  localparam logic [4:0] ADR_SINE_GAIN = 5'h01;
  localparam logic [4:0] ADR_ROUTE = 5'h02;
  localparam logic [4:0] ADR_DIVISOR = 5'h03;
  localparam logic [4:0] ADR_GAIN0 = 5'h04;
  localparam logic [4:0] ADR_GAIN1 = 5'h05;
  localparam logic [4:0] ADR_GAIN2 = 5'h06;
  localparam logic [4:0] ADR_LVL_A = 5'h07;
  localparam logic [4:0] ADR_LVL_B = 5'h08;

  // reset values
  localparam logic [7:0] RST_MODE_REG = 8'h18;
  localparam logic [7:0] RST_DIVISOR = 8'h07;
  localparam logic [7:0] RST_OTHER = 8'h00;

  // field positions
  localparam int MODE_LSB = 0;
  localparam int RANGE_LSB = 2;
  localparam int ID_LSB = 5;
  localparam int BAND_BIT = 7;
  localparam int PATH_LSB = 4;
  localparam int MULT_LSB = 0;
  localparam int LVL_W = 5;

  // operating modes
  localparam logic [1:0] MODE_SINE = 2'h0;
  localparam logic [1:0] MODE_STEADY = 2'h1;
  localparam logic [1:0] MODE_DIGITAL = 2'h2;
  localparam logic [1:0] MODE_PULSE = 2'h3;

  // command opcodes (upper nibble of first byte, or seven upper bits for reset)
  localparam logic [3:0] OPC_WRITE = 4'h4;
  localparam logic [3:0] OPC_READ = 4'h2;
  localparam logic [6:0] OPC_RESET = 7'h03;

  // switch element closures: [0] in_pos-out_pos [1] in_neg-out_neg [2] in_pos-out_neg
  // [3] in_neg-out_pos [4] out_pos-out_neg
  localparam logic [4:0] CLS_OPEN = 5'h00;
  localparam logic [4:0] CLS_PP = 5'h01;
  localparam logic [4:0] CLS_NN = 5'h02;
  localparam logic [4:0] CLS_PN = 5'h04;
  localparam logic [4:0] CLS_NP = 5'h08;
  localparam logic [4:0] CLS_SHORT = 5'h10;

  typedef logic [7:0] tss_byte_t;
  typedef enum logic [1:0] {ST_OP1, ST_OP2, ST_DATA} tss_state_t;

  // route code to switch element closures
  function automatic logic [4:0] route_decode(input logic [2:0] path_select_bits);
    logic [4:0] c;
    c = CLS_OPEN;
    case (path_select_bits)
      3'h1: c = CLS_PP | CLS_NN;
      3'h2: c = CLS_PN | CLS_NP;
      3'h3: c = CLS_PP | CLS_PN;
      3'h4: c = CLS_NP | CLS_NN;
      3'h5: c = CLS_PP;
      3'h6: c = CLS_NN;
      3'h7: c = CLS_SHORT;
      default: c = CLS_OPEN;
    endcase
    return c;
  endfunction

endpackage

// ===== tss_reg_if.sv
// link between the command engine and the register bank
`timescale 1ns/1ns
interface tss_reg_if;
  import tss_pkg::*;
  logic we;
  logic [4:0] addr;
  tss_byte_t wdata;
  logic soft_clr;
  tss_byte_t rdata;
  logic [REG_CNT-1:0][7:0] regs;

  modport ctrl (output we, output addr, output wdata, output soft_clr, input rdata, input regs);
  modport bank (input we, input addr, input wdata, input soft_clr, output rdata, output regs);
endinterface

// ===== tss_reg_bank.sv
// byte register bank with registered read port
`timescale 1ns/1ns
module tss_reg_bank #(
  parameter int NUM_REGS = tss_pkg::REG_CNT,
  parameter logic [2:0] ID_VALUE = 3'h5 // arbitrary identification value
) (
  input wire logic core_clk,
  input wire logic rst,
  tss_reg_if.bank rb
);
  import tss_pkg::*;

  logic [REG_CNT-1:0][7:0] regs_r;
  tss_byte_t rdata_r;

  // the map and the address decode are fixed at nine registers
  if (NUM_REGS != REG_CNT) begin : g_bad_size
    $error("tss_reg_bank: NUM_REGS must equal REG_CNT");
  end

  function automatic tss_byte_t reset_value(input int idx);
    if (idx == int'(ADR_MODE)) begin
      return RST_MODE_REG;
    end
    if (idx == int'(ADR_DIVISOR)) begin
      return RST_DIVISOR;
    end
    return RST_OTHER;
  endfunction

  // storage; pin reset and the reset command both restore defaults
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < REG_CNT; i++) begin
        regs_r[i] <= reset_value(i);
      end
    end else if (rb.soft_clr) begin
      for (int i = 0; i < REG_CNT; i++) begin
        regs_r[i] <= reset_value(i);
      end
    end else if (rb.we && rb.addr < 5'(REG_CNT)) begin
      case (rb.addr) // R13
        ADR_MODE: regs_r[ADR_MODE] <= {3'h0, rb.wdata[ID_LSB-1:0]}; // id bits are read-only
        ADR_LVL_A: regs_r[ADR_LVL_A] <= {3'h0, rb.wdata[LVL_W-1:0]}; // R10
        ADR_LVL_B: regs_r[ADR_LVL_B] <= {3'h0, rb.wdata[LVL_W-1:0]}; // R10
        default: regs_r[rb.addr[3:0]] <= rb.wdata;
      endcase
    end
  end

  // read data from a flop; addresses past the map read zero
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata_r <= 8'h00;
    end else if (rb.addr >= 5'(REG_CNT)) begin
      rdata_r <= 8'h00;
    end else if (rb.addr == ADR_MODE) begin
      rdata_r <= {ID_VALUE, regs_r[ADR_MODE][ID_LSB-1:0]};
    end else begin
      rdata_r <= regs_r[rb.addr[3:0]];
    end
  end

  assign rb.rdata = rdata_r;
  assign rb.regs = regs_r;
endmodule

// ===== tss_host_model.sv
// host controller model that drives the serial command port
`timescale 1ns/1ns
module tss_host_model (
  input wire logic core_clk,
  output logic chip_sel_low,
  output logic sclk,
  output logic sdin,
  input wire logic sdout
);
  import tss_pkg::*;

  // idle: deselected, link clock parked low between frames
  initial begin
    chip_sel_low = 1'b1;
    sclk = 1'b0;
    sdin = 1'b0;
  end

  // four core cycles per half period gives the 800 ns link period
  task automatic half();
    repeat (4) @(posedge core_clk);
  endtask

  // one byte each way, msb first; sdout is taken late in the high phase, well after its update
  task automatic xfer(input tss_byte_t tx, output tss_byte_t rx);
    for (int i = 7; i >= 0; i--) begin
      sdin <= tx[i];
      half();
      sclk <= 1'b1;
      half();
      rx[i] = sdout;
      sclk <= 1'b0;
    end
  endtask

  // chip select stays low for the whole command
  task automatic begin_frame();
    @(posedge core_clk);
    chip_sel_low <= 1'b0;
    half();
  endtask

  // a released data line must not keep showing the last bit
  task automatic end_frame();
    half();
    chip_sel_low <= 1'b1;
    sdin <= ~sdin;
    half();
  endtask

  // write command: opcode with start address, count minus one, then the data bytes
  task automatic write_regs(input logic [3:0] adr, input tss_byte_t d[$]);
    tss_byte_t r;
    begin_frame();
    xfer({OPC_WRITE, adr}, r);
    xfer(tss_byte_t'(d.size() - 1), r);
    foreach (d[k]) xfer(d[k], r);
    end_frame();
  endtask

  // read command: opcode, count minus one, then n bytes clocked out
  task automatic read_regs(input logic [3:0] adr, input int n, output tss_byte_t q[$]);
    tss_byte_t r;
    q = {};
    begin_frame();
    xfer({OPC_READ, adr}, r);
    xfer(tss_byte_t'(n - 1), r);
    for (int k = 0; k < n; k++) begin
      xfer(8'h00, r);
      q.push_back(r);
    end
    end_frame();
  endtask

  // single-byte reset command
  task automatic reset_cmd();
    tss_byte_t r;
    begin_frame();
    xfer(8'h06, r);
    end_frame();
  endtask
endmodule

// ===== tss_regs_top_test.sv
// self-checking bench for the switch, tone, gain and pulse level registers
`timescale 1ns/1ns
module tss_regs_top_test;
  import tss_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic route_gate_pin = 1'b0;
  logic level_sel_pin = 1'b0;
  logic chip_sel_low;
  logic sclk;
  logic sdin;
  logic sdout;
  logic sdout_oe_low;
  logic [4:0] switch_close;
  logic [1:0] op_mode;
  logic [2:0] range_sel;
  tss_byte_t sine_gain;
  logic tone_band_bit;
  logic [3:0] tone_mult;
  tss_byte_t tone_divisor;
  logic [23:0] steady_level_gain;
  logic [4:0] level_out;
  logic gen_restart;
  int n_mismatch = 0;
  int checked = 0;
  int n_restart = 0;
  // expected closures per route code, written out independently of the design decode
  logic [4:0] sw_exp [8] = '{5'h00, 5'h03, 5'h0c, 5'h05, 5'h0a, 5'h01, 5'h02, 5'h10};

  always #50 core_clk = ~core_clk;

  tss_regs_top tss_regs_top_inst (.core_clk(core_clk), .rst(rst), .chip_sel_low(chip_sel_low), .sclk(sclk),
    .sdin(sdin), .sdout(sdout), .sdout_oe_low(sdout_oe_low), .route_gate_pin(route_gate_pin),
    .level_sel_pin(level_sel_pin), .switch_close(switch_close), .op_mode(op_mode), .range_sel(range_sel),
    .sine_gain(sine_gain), .tone_band_bit(tone_band_bit), .tone_mult(tone_mult), .tone_divisor(tone_divisor),
    .steady_level_gain(steady_level_gain), .level_out(level_out), .gen_restart(gen_restart));
  tss_host_model tss_host_model_inst (.core_clk(core_clk), .chip_sel_low(chip_sel_low), .sclk(sclk),
    .sdin(sdin), .sdout(sdout));

  // count generator restart pulses so mode changes can be judged
  always @(posedge core_clk) if (gen_restart === 1'b1) n_restart++;

  task automatic chk_port(input string what, input logic [23:0] exp, input logic [23:0] seen);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic chk_byte(input string what, input tss_byte_t exp, input tss_byte_t seen);
    chk_port(what, {16'h0000, exp}, {16'h0000, seen});
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic t_reset();
    tss_byte_t q[$];
    chk_port("switch_close", 24'h0, {19'h0, switch_close});
    chk_port("tone_divisor", 24'h7, {16'h0, tone_divisor});
    chk_port("steady_level_gain", 24'h0, steady_level_gain);
    chk_port("op_mode", 24'h0, {22'h0, op_mode});
    chk_port("range_sel", 24'h6, {21'h0, range_sel});
    chk_port("sine_gain", 24'h0, {16'h0, sine_gain});
    tss_host_model_inst.read_regs(4'h0, 10, q);
    chk_port("sdout_oe_low idle", 24'h1, {23'h0, sdout_oe_low});
    chk_byte("reg0 low bits", 8'h18, q[0] & 8'h1f);
    for (int k = 1; k < 10; k++) chk_byte("read back", (k == 3) ? 8'h07 : 8'h00, q[k]);
  endtask

  task automatic t_route();
    int r0;
    for (int c = 0; c < 8; c++) begin
      tss_host_model_inst.write_regs(4'h2, '{{1'b0, 3'(c), 4'h0}});
      @(posedge core_clk) route_gate_pin <= 1'b1;
      settle(6);
      chk_port("switch_close gated", {19'h0, sw_exp[c]}, {19'h0, switch_close});
      @(posedge core_clk) route_gate_pin <= 1'b0;
      settle(6);
      chk_port("switch_close open", 24'h0, {19'h0, switch_close});
    end
    // digital data mode follows the register alone, with the gate held low
    r0 = n_restart;
    tss_host_model_inst.write_regs(4'h0, '{8'h0e});
    settle(4);
    chk_port("op_mode", 24'h2, {22'h0, op_mode});
    chk_port("range_sel", 24'h3, {21'h0, range_sel});
    chk_port("restart pulses", 24'h1, 24'(n_restart - r0));
    chk_port("switch_close digital", 24'h10, {19'h0, switch_close});
    tss_host_model_inst.write_regs(4'h0, '{8'h18});
  endtask

  task automatic t_tone();
    tss_host_model_inst.write_regs(4'h1, '{8'h3c, 8'hb5, 8'ha7});
    @(posedge core_clk) route_gate_pin <= 1'b1;
    settle(6);
    chk_port("sine_gain", 24'h3c, {16'h0, sine_gain});
    chk_port("tone_band_bit", 24'h1, {23'h0, tone_band_bit});
    chk_port("tone_mult", 24'h5, {20'h0, tone_mult});
    chk_port("tone_divisor", 24'ha7, {16'h0, tone_divisor});
    chk_port("switch_close", 24'h05, {19'h0, switch_close});
  endtask

  task automatic t_gain_pulse();
    tss_byte_t q[$];
    int r0;
    tss_host_model_inst.write_regs(4'h4, '{8'h11, 8'h22, 8'h33});
    settle(4);
    chk_port("steady_level_gain", 24'h332211, steady_level_gain);
    // last byte lands past the map and is dropped; reserved level bits sent as zero
    tss_host_model_inst.write_regs(4'h7, '{8'h15, 8'h0a, 8'hff});
    settle(4);
    chk_port("level_out sine", 24'h0, {19'h0, level_out});
    tss_host_model_inst.write_regs(4'h0, '{8'h19});
    settle(4);
    chk_port("op_mode steady", 24'h1, {22'h0, op_mode});
    chk_port("level_out steady", 24'h0, {19'h0, level_out});
    r0 = n_restart;
    tss_host_model_inst.write_regs(4'h0, '{8'h1b});
    settle(6);
    chk_port("restart pulses", 24'h1, 24'(n_restart - r0));
    chk_port("level_out a", 24'h15, {19'h0, level_out});
    @(posedge core_clk) level_sel_pin <= 1'b1;
    settle(6);
    chk_port("level_out b", 24'h0a, {19'h0, level_out});
    tss_host_model_inst.read_regs(4'h7, 3, q);
    chk_byte("level a reg", 8'h15, q[0]);
    chk_byte("level b reg", 8'h0a, q[1]);
    chk_byte("past map", 8'h00, q[2]);
  endtask

  task automatic t_abort_reset();
    tss_byte_t r;
    // partial write cut off by chip select must leave the divisor alone
    tss_host_model_inst.begin_frame();
    tss_host_model_inst.xfer(8'h43, r);
    tss_host_model_inst.xfer(8'h00, r);
    tss_host_model_inst.end_frame();
    settle(4);
    chk_port("tone_divisor kept", 24'ha7, {16'h0, tone_divisor});
    tss_host_model_inst.reset_cmd();
    settle(6);
    chk_port("tone_divisor reset", 24'h07, {16'h0, tone_divisor});
    chk_port("steady reset", 24'h0, steady_level_gain);
    chk_port("switch reset", 24'h0, {19'h0, switch_close});
  endtask

  task automatic final_report();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    settle(4);
    t_reset();
    t_route();
    t_tone();
    t_gain_pulse();
    t_abort_reset();
    final_report();
  end

  // the whole sequence needs roughly 5000 core cycles
  initial begin
    repeat (30000) @(posedge core_clk);
    n_mismatch++;
    final_report();
  end
endmodule
